// ### pkg/ccrpc_pkg.sv
/*
 * Shared constants for the chip clock, reset and pin control block.
 * Assumes a single 50 MHz core clock taken from the 24 MHz reference.
 */
package ccrpc_pkg;

    // ----------------------------------------------------------------
    // Clocking
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int REF_CLK_MHZ = 24;
    localparam int DMA_INT_DIV = 6;
    localparam logic [3:0] MCU_HALF_SEL0 = 4'h1;
    localparam logic [3:0] MCU_HALF_SEL1 = 4'h2;
    localparam logic [3:0] MCU_HALF_SEL2 = 4'h4;
    localparam logic [3:0] MCU_HALF_SEL3 = 4'h8;

    // ----------------------------------------------------------------
    // Timing, in ns and in clock cycles
    // ----------------------------------------------------------------
    localparam int RST_HOLD_NS = 200;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int FLASH_ALE_NS = 40;
    localparam int FLASH_ALE_CYC = (FLASH_ALE_NS * CLK_MHZ + 999) / 1000;
    localparam int FLASH_STROBE_NS = 100;
    localparam int FLASH_STROBE_CYC = (FLASH_STROBE_NS * CLK_MHZ + 999) / 1000;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int PORT_W = 4;
    localparam int FADDR_W = 20;
    localparam int FDATA_W = 8;
    localparam int GPIO_W = 8;
    localparam int SYNC_W = 25;
    localparam logic [PORT_W-1:0] PORT_OFF = 4'hf;
    localparam logic [GPIO_W-1:0] GPIO_ALL_IN = 8'hff;
    // pg=0 reset=1 test=1 dmaclk=0 ovc=f gpio=0 fd=0 chain=1
    localparam logic [SYNC_W-1:0] SYNC_INIT = 25'h0de0001;

    typedef enum logic [3:0] {
        FL_IDLE = 4'b0001,
        FL_ALE = 4'b0010,
        FL_STROBE = 4'b0100,
        FL_DONE = 4'b1000
    } ccrpc_flash_e;

endpackage

// ### design/ccrpc_sync.sv
/*
 * Two-flop synchroniser for a bundle of pin inputs.
 * Assumes every bit is an independent level; no word coherence.
 */
`timescale 1ns/10ps
module ccrpc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // ccrpc_sync

// ### design/ccrpc_chip_control.sv
/*
 * Chip level clock, reset and pin control: clock out, DMA clock pick,
 * power-on reset, port power, flash strobes, GPIO direction, test chain.
 * Assumes clk is the core clock made from the 24 MHz reference and that
 * pin inputs are asynchronous; pads resolve the active-low enables.
 */
`timescale 1ns/10ps
module ccrpc_chip_control
    import ccrpc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic powerGoodIn,
    input wire logic resetIn,
    input wire logic factoryTestN,
    input wire logic dmaAltClock,
    input wire logic dmaClkSelExt,
    input wire logic mcuStop,
    input wire logic [1:0] mcuDivSel,
    input wire logic [PORT_W-1:0] portPowerReq,
    input wire logic [PORT_W-1:0] portOvercurrentSenseN,
    input wire logic flashReq,
    input wire logic flashWrite,
    input wire logic [FADDR_W-1:0] flashReqAddr,
    input wire logic [FDATA_W-1:0] flashWrData,
    input wire logic [FDATA_W-1:0] flashDataIn,
    input wire logic [GPIO_W-1:0] gpioDir,
    input wire logic [GPIO_W-1:0] gpioOutVal,
    input wire logic [GPIO_W-1:0] gpioPinIn,
    input wire logic testChainIn,
    output logic coreRstN,
    output logic mcuClockOut,
    output logic mcuClockOeN,
    output logic dmaClkEn,
    output logic [PORT_W-1:0] portPowerOnN,
    output logic portPowerOeN,
    output logic [PORT_W-1:0] portOvercurrent,
    output logic overcurrentEvent,
    output logic [FADDR_W-1:0] flashAddr,
    output logic flashAddrOeN,
    output logic [FDATA_W-1:0] flashDataOut,
    output logic flashDataOeN,
    output logic flashReadN,
    output logic flashWriteN,
    output logic flashSelectN,
    output logic flashAddrLatch,
    output logic flashCtrlOeN,
    output logic flashBusy,
    output logic flashDone,
    output logic [FDATA_W-1:0] flashRdData,
    output logic [GPIO_W-1:0] gpioPinOut,
    output logic [GPIO_W-1:0] gpioPinOeN,
    output logic [GPIO_W-1:0] gpioInVal,
    output logic testChainOut,
    output logic testChainOeN,
    output logic debugMode
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam logic [3:0] RST_LAST = 4'(RST_HOLD_CYC - 1);
    localparam logic [2:0] ALE_LAST = 3'(FLASH_ALE_CYC - 1);
    localparam logic [2:0] STB_LAST = 3'(FLASH_STROBE_CYC - 1);
    localparam logic [2:0] DMA_LAST = 3'(DMA_INT_DIV - 1);

    logic [SYNC_W-1:0] syncD;
    logic [SYNC_W-1:0] syncQ;
    wire pgS;
    wire rstInS;
    wire ftestS;
    wire dmaExtS;
    wire [PORT_W-1:0] ocNS;
    wire [GPIO_W-1:0] gpioS;
    wire [FDATA_W-1:0] fdS;
    wire testInS;

    assign syncD = {powerGoodIn, resetIn, factoryTestN, dmaAltClock, portOvercurrentSenseN,
                    gpioPinIn, flashDataIn, testChainIn};

    // Test input idles high, as the board is expected to hold it
    ccrpc_sync #(.WIDTH(SYNC_W), .INIT(SYNC_INIT)) uSync (
        .clk(clk),
        .rstn(rstn),
        .d(syncD),
        .q(syncQ)
    );

    assign {pgS, rstInS, ftestS, dmaExtS, ocNS, gpioS, fdS, testInS} = syncQ;

    // ----------------------------------------------------------------
    // Power-on reset
    // ----------------------------------------------------------------
    logic [3:0] rstCnt_q;
    wire porActive = !pgS || rstInS;
    wire run = coreRstN && pgS;

    // Release only after a held quiet spell, on a clock edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstCnt_q <= 4'h0;
            coreRstN <= 1'b0;
        end else if (porActive) begin
            rstCnt_q <= 4'h0;
            coreRstN <= 1'b0;
        end else if (!coreRstN) begin
            rstCnt_q <= rstCnt_q + 4'h1;
            coreRstN <= (rstCnt_q == RST_LAST);
        end
    end

    // ----------------------------------------------------------------
    // Microcontroller clock output
    // ----------------------------------------------------------------
    function automatic logic [3:0] mcuHalfPeriod(input logic [1:0] sel);
        unique case (sel)
            2'h0: mcuHalfPeriod = MCU_HALF_SEL0;
            2'h1: mcuHalfPeriod = MCU_HALF_SEL1;
            2'h2: mcuHalfPeriod = MCU_HALF_SEL2;
            2'h3: mcuHalfPeriod = MCU_HALF_SEL3;
        endcase
    endfunction

    logic [3:0] mcuDivCnt_q;
    // Greater-or-equal so a faster selection never strands the counter
    wire mcuDivLast = mcuDivCnt_q >= (mcuHalfPeriod(mcuDivSel) - 4'h1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mcuDivCnt_q <= 4'h0;
            mcuClockOut <= 1'b0;
            mcuClockOeN <= 1'b1;
        end else begin
            mcuClockOeN <= !pgS;
            if (!run) begin
                mcuDivCnt_q <= 4'h0;
                mcuClockOut <= 1'b0;
            end else if (!mcuStop) begin
                mcuDivCnt_q <= mcuDivLast ? 4'h0 : mcuDivCnt_q + 4'h1;
                mcuClockOut <= mcuDivLast ? !mcuClockOut : mcuClockOut;
            end
        end
    end

    // ----------------------------------------------------------------
    // DMA clock enable
    // ----------------------------------------------------------------
    logic [2:0] dmaIntCnt_q;
    logic dmaExtPrev_q;
    wire dmaIntTick = (dmaIntCnt_q == DMA_LAST);
    wire dmaExtRise = dmaExtS && !dmaExtPrev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dmaIntCnt_q <= 3'h0;
            dmaExtPrev_q <= 1'b0;
            dmaClkEn <= 1'b0;
        end else begin
            dmaIntCnt_q <= dmaIntTick ? 3'h0 : dmaIntCnt_q + 3'h1;
            dmaExtPrev_q <= dmaExtS;
            dmaClkEn <= run && (dmaClkSelExt ? dmaExtRise : dmaIntTick);
        end
    end

    // ----------------------------------------------------------------
    // Port power and over-current
    // ----------------------------------------------------------------
    wire [PORT_W-1:0] ocNew = ~ocNS & ~portOvercurrent;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            portPowerOnN <= PORT_OFF;
            portPowerOeN <= 1'b1;
            portOvercurrent <= '0;
            overcurrentEvent <= 1'b0;
        end else begin
            portPowerOnN <= run ? ~portPowerReq : PORT_OFF;
            portPowerOeN <= !pgS;
            portOvercurrent <= ~ocNS;
            overcurrentEvent <= run && (|ocNew);
        end
    end

    // ----------------------------------------------------------------
    // GPIO
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gpioPinOut <= '0;
            gpioPinOeN <= GPIO_ALL_IN;
            gpioInVal <= '0;
        end else begin
            gpioPinOut <= run ? gpioOutVal : '0;
            gpioPinOeN <= run ? ~gpioDir : GPIO_ALL_IN;
            gpioInVal <= gpioS;
        end
    end

    // ----------------------------------------------------------------
    // Test chain and debugger mode
    // ----------------------------------------------------------------
    // Chain pin is released while the test input is low, so it can be read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            testChainOut <= 1'b0;
            testChainOeN <= 1'b0;
            debugMode <= 1'b0;
        end else begin
            testChainOut <= ~^syncQ[SYNC_W-1:1];
            testChainOeN <= !ftestS;
            debugMode <= !ftestS && !testInS;
        end
    end

    // ----------------------------------------------------------------
    // Flash access engine
    // ----------------------------------------------------------------
    ccrpc_flash_e state_q;
    ccrpc_flash_e stateD;
    logic [2:0] flCnt_q;
    logic [2:0] flCntD;
    logic opWrite_q;

    always_comb begin
        stateD = state_q;
        flCntD = flCnt_q;
        unique case (state_q)
            FL_IDLE: begin
                if (flashReq && !debugMode) begin
                    stateD = FL_ALE;
                    flCntD = 3'h0;
                end
            end
            FL_ALE: begin
                flCntD = flCnt_q + 3'h1;
                if (flCnt_q == ALE_LAST) begin
                    stateD = FL_STROBE;
                    flCntD = 3'h0;
                end
            end
            FL_STROBE: begin
                flCntD = flCnt_q + 3'h1;
                if (flCnt_q == STB_LAST) begin
                    stateD = FL_DONE;
                end
            end
            FL_DONE: begin
                stateD = FL_IDLE;
            end
        endcase
    end

    wire wrD = (state_q == FL_IDLE) ? flashWrite : opWrite_q;
    wire inStrobeD = (stateD == FL_STROBE);
    wire inAccessD = (stateD == FL_ALE) || inStrobeD;
    wire flPinsOff = !pgS || debugMode;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= FL_IDLE;
            flCnt_q <= 3'h0;
            opWrite_q <= 1'b0;
            flashAddr <= '0;
            flashDataOut <= '0;
        end else if (!run) begin
            state_q <= FL_IDLE;
            flCnt_q <= 3'h0;
        end else begin
            state_q <= stateD;
            flCnt_q <= flCntD;
            if (state_q == FL_IDLE && stateD == FL_ALE) begin
                opWrite_q <= flashWrite;
                flashAddr <= flashReqAddr;
                flashDataOut <= flashWrData;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flashAddrOeN <= 1'b1;
            flashCtrlOeN <= 1'b1;
            flashDataOeN <= 1'b1;
            flashReadN <= 1'b1;
            flashWriteN <= 1'b1;
            flashSelectN <= 1'b1;
            flashAddrLatch <= 1'b0;
            flashBusy <= 1'b0;
            flashDone <= 1'b0;
            flashRdData <= '0;
        end else begin
            flashAddrOeN <= flPinsOff;
            flashCtrlOeN <= flPinsOff;
            flashDataOeN <= flPinsOff || !(run && inStrobeD && wrD);
            flashReadN <= !(run && inStrobeD && !wrD);
            flashWriteN <= !(run && inStrobeD && wrD);
            flashSelectN <= !(run && inAccessD);
            flashAddrLatch <= run && (stateD == FL_ALE);
            flashBusy <= run && (stateD != FL_IDLE);
            flashDone <= run && (stateD == FL_DONE);
            if (run && stateD == FL_DONE && !opWrite_q) begin
                flashRdData <= fdS;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_pins_float: assert property (!pgS |=> (portPowerOeN && mcuClockOeN && flashAddrOeN
        && flashCtrlOeN && flashDataOeN && gpioPinOeN == GPIO_ALL_IN))
        else $error("pins driven while power not good");
    a_por_pg: assert property (!pgS |=> !coreRstN)
        else $error("reset not forced by power loss");
    a_por_reset: assert property (rstInS |=> !coreRstN ##1 !coreRstN)
        else $error("reset not forced by reset input");
    a_por_release: assert property ($rose(coreRstN) |-> $past(!porActive, 2))
        else $error("reset released without quiet spell");
    a_clk_halt: assert property ((run && mcuStop) [*2] |-> $stable(mcuClockOut))
        else $error("clock out moved while stopped");
    a_clk_rate: assert property ((run && !mcuStop && mcuDivSel == 2'h0) [*3]
        |-> $changed(mcuClockOut))
        else $error("clock out not at selected rate");
    a_port_on: assert property ((run && portPowerReq[0]) |=> !portPowerOnN[0])
        else $error("requested port not powered");
    a_port_default: assert property (!coreRstN |=> portPowerOnN == PORT_OFF)
        else $error("port power on during reset");
    a_ovc_seen: assert property (!ocNS[0] |=> portOvercurrent[0])
        else $error("over-current not reported");
    a_gpio_dir: assert property (run |=> gpioPinOeN == ~$past(gpioDir))
        else $error("output pin not driven");
    a_rd_strobe: assert property ($fell(flashReadN) |-> (!flashSelectN && flashWriteN
        && flashDataOeN && $past(flashAddrLatch)))
        else $error("read strobe out of sequence");
    a_wr_strobe: assert property ($fell(flashWriteN) |-> (!flashSelectN && flashReadN
        && !flashDataOeN))
        else $error("write strobe out of sequence");
    a_ale_select: assert property ($rose(flashAddrLatch) |-> !flashSelectN
        ##1 flashAddrLatch ##1 !flashAddrLatch)
        else $error("address latch timing wrong");
    a_test_release: assert property (!ftestS |=> testChainOeN)
        else $error("chain pin not released");

    c_flash_read: cover property (flashDone && !opWrite_q);
    c_flash_write: cover property (flashDone && opWrite_q);
    c_debug_entry: cover property ($rose(debugMode));
    c_reset_release: cover property ($rose(coreRstN));

endmodule // ccrpc_chip_control

// ### tb/ccrpc_far_side.sv
/*
 * Board side of the chip control block: a byte-wide flash memory and the
 * four downstream port power switches with their over-current flags.
 * Assumes the bench feeds the fault requests and the core clock.
 */
`timescale 1ns/10ps
module ccrpc_far_side (
    input wire logic clk,
    input wire logic [19:0] flashAddr,
    input wire logic [7:0] flashDataOut,
    input wire logic flashDataOeN,
    input wire logic flashReadN,
    input wire logic flashWriteN,
    input wire logic flashSelectN,
    input wire logic flashCtrlOeN,
    output logic [7:0] flashDataIn,
    input wire logic [3:0] portPowerOnN,
    input wire logic portPowerOeN,
    input wire logic [3:0] portFault,
    output logic [3:0] portOvercurrentSenseN
);
    // ----------------------------------------------------------------
    // Flash array
    // ----------------------------------------------------------------
    logic [7:0] mem [0:(1<<20)-1];
    bit written [0:(1<<20)-1];
    logic [7:0] memVal;
    logic [7:0] lastOut = 8'h00;
    logic selected;
    logic readOn;

    assign selected = !flashCtrlOeN && !flashSelectN;
    assign readOn = selected && !flashReadN;
    // Cells never written read as erased
    assign memVal = written[flashAddr] ? mem[flashAddr] : 8'hff;
    // Undriven bus shows the inverse of the last driven value, not a stale copy
    assign flashDataIn = readOn ? memVal : (!flashDataOeN ? flashDataOut : ~lastOut);
    always @(posedge clk) begin
        if (readOn || !flashDataOeN) begin
            lastOut <= flashDataIn;
        end
        if (selected && !flashWriteN && !flashDataOeN) begin
            mem[flashAddr] <= flashDataOut;
            written[flashAddr] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Power switches: flag only a powered port that overloads
    // ----------------------------------------------------------------
    assign portOvercurrentSenseN = ~(portFault & ~portPowerOnN & {4{!portPowerOeN}});
endmodule // ccrpc_far_side

// ### tb/ccrpc_chip_control_tb.sv
/*
 * Self-checking bench for the chip clock, reset and pin control block.
 * Assumes the flash and power switch model of ccrpc_far_side.
 */
`timescale 1ns/10ps
module ccrpc_chip_control_tb;
    import ccrpc_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, powerGoodIn = 1'b1, resetIn = 1'b0, factoryTestN = 1'b1;
    logic dmaAltClock = 1'b0, dmaClkSelExt = 1'b0, mcuStop = 1'b0, flashReq = 1'b0;
    logic flashWrite = 1'b0, tbChain = 1'b1;
    logic [1:0] mcuDivSel = 2'h0;
    logic [3:0] portPowerReq = 4'h0, portFault = 4'h0, portOvercurrentSenseN;
    logic [19:0] flashReqAddr = 20'h00000;
    logic [7:0] flashWrData = 8'h00, gpioDir = 8'h00, gpioOutVal = 8'h00, gpioPinIn = 8'h00;
    logic [7:0] flashDataIn;
    wire logic testChainIn;
    logic coreRstN, mcuClockOut, mcuClockOeN, dmaClkEn, portPowerOeN, overcurrentEvent;
    logic [3:0] portPowerOnN, portOvercurrent;
    logic [19:0] flashAddr;
    logic flashAddrOeN, flashDataOeN, flashReadN, flashWriteN, flashSelectN, flashAddrLatch;
    logic flashCtrlOeN, flashBusy, flashDone, testChainOut, testChainOeN, debugMode;
    logic [7:0] flashDataOut, flashRdData, gpioPinOut, gpioPinOeN, gpioInVal;
    int nMismatch = 0, testsRun = 0;

    // Chain pin seen by the chip: its own drive, or the board when released
    assign testChainIn = testChainOeN ? tbChain : testChainOut;
    initial begin
        forever #10 clk = ~clk;
    end

    ccrpc_chip_control i_dut (.clk(clk), .rstn(rstn), .powerGoodIn(powerGoodIn),
        .resetIn(resetIn), .factoryTestN(factoryTestN), .dmaAltClock(dmaAltClock),
        .dmaClkSelExt(dmaClkSelExt), .mcuStop(mcuStop), .mcuDivSel(mcuDivSel),
        .portPowerReq(portPowerReq), .portOvercurrentSenseN(portOvercurrentSenseN),
        .flashReq(flashReq), .flashWrite(flashWrite), .flashReqAddr(flashReqAddr),
        .flashWrData(flashWrData), .flashDataIn(flashDataIn), .gpioDir(gpioDir),
        .gpioOutVal(gpioOutVal), .gpioPinIn(gpioPinIn), .testChainIn(testChainIn),
        .coreRstN(coreRstN), .mcuClockOut(mcuClockOut), .mcuClockOeN(mcuClockOeN),
        .dmaClkEn(dmaClkEn), .portPowerOnN(portPowerOnN), .portPowerOeN(portPowerOeN),
        .portOvercurrent(portOvercurrent), .overcurrentEvent(overcurrentEvent),
        .flashAddr(flashAddr), .flashAddrOeN(flashAddrOeN), .flashDataOut(flashDataOut),
        .flashDataOeN(flashDataOeN), .flashReadN(flashReadN), .flashWriteN(flashWriteN),
        .flashSelectN(flashSelectN), .flashAddrLatch(flashAddrLatch),
        .flashCtrlOeN(flashCtrlOeN), .flashBusy(flashBusy), .flashDone(flashDone),
        .flashRdData(flashRdData), .gpioPinOut(gpioPinOut), .gpioPinOeN(gpioPinOeN),
        .gpioInVal(gpioInVal), .testChainOut(testChainOut), .testChainOeN(testChainOeN),
        .debugMode(debugMode));

    ccrpc_far_side i_far (.clk(clk), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
        .flashDataOeN(flashDataOeN), .flashReadN(flashReadN), .flashWriteN(flashWriteN),
        .flashSelectN(flashSelectN), .flashCtrlOeN(flashCtrlOeN), .flashDataIn(flashDataIn),
        .portPowerOnN(portPowerOnN), .portPowerOeN(portPowerOeN), .portFault(portFault),
        .portOvercurrentSenseN(portOvercurrentSenseN));

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic expect_true(input logic ok, input string what);
        testsRun++;
        if (ok !== 1'b1) begin
            nMismatch++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask

    task automatic close_out();
        $display("comparisons=%0d mismatches=%0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Release must wait out the hold count, then arrive within a bound
    task automatic wait_core();
        int n;
        n = 0;
        while (coreRstN !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        expect_true(n >= RST_HOLD_CYC && n < 40, "core reset release timing");
    endtask

    // One flash access; done comes the ALE plus strobe cycles after the taking edge
    task automatic flash_op(input logic wr, input logic [19:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        flashReq <= 1'b1;
        flashWrite <= wr;
        flashReqAddr <= a;
        flashWrData <= d;
        @(posedge clk);
        flashReq <= 1'b0;
        n = 0;
        do begin
            step(1);
            n++;
            if (n == 1) expect_true(flashAddrLatch === 1'b1 && flashSelectN === 1'b0
                && flashBusy === 1'b1, "ale");
            if (n == 4) expect_true((wr ? flashWriteN : flashReadN) === 1'b0, "strobe");
            if (n == 4) expect_true(flashAddr === a && flashAddrLatch === 1'b0, "addr");
        end while (flashDone !== 1'b1 && n < 20);
        expect_true(n == FLASH_ALE_CYC + FLASH_STROBE_CYC, "flash done latency");
        expect_true((wr ? flashWriteN : flashReadN) === 1'b1
            && flashSelectN === 1'b1, "strobe release");
        step(1);
        expect_true(flashBusy === 1'b0 && flashDone === 1'b0, "busy clear");
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults();
        expect_true(portPowerOnN === PORT_OFF && gpioPinOeN === 8'hff, "reset dirs");
        expect_true(testChainOeN === 1'b0, "chain driven");
    endtask

    task automatic t_flash();
        flash_op(1'b1, 20'hfffff, 8'ha5);
        flash_op(1'b1, 20'h00000, 8'h3c);
        flash_op(1'b0, 20'hfffff, 8'h00);
        expect_true(flashRdData === 8'ha5, "read top");
        flash_op(1'b0, 20'h00000, 8'h00);
        expect_true(flashRdData === 8'h3c, "read bottom");
        flash_op(1'b0, 20'h12345, 8'h00);
        expect_true(flashRdData === 8'hff, "read blank");
    endtask

    task automatic t_ports();
        @(posedge clk);
        portPowerReq <= 4'h5;
        step(3);
        expect_true(portPowerOnN === 4'ha && portPowerOeN === 1'b0, "port power");
        portFault <= 4'h3;
        step(3);
        expect_true(overcurrentEvent === 1'b1 && portOvercurrent === 4'h1, "oc event");
        step(3);
        expect_true(portOvercurrent === 4'h1 && overcurrentEvent === 1'b0, "overcurrent");
        portFault <= 4'h0;
        step(6);
        expect_true(portOvercurrent === 4'h0, "overcurrent clear");
    endtask

    task automatic t_gpio();
        logic c;
        @(posedge clk);
        gpioDir <= 8'h5a;
        gpioOutVal <= 8'hc3;
        gpioPinIn <= 8'h96;
        step(5);
        expect_true(gpioPinOeN === 8'ha5, "gpio dir");
        expect_true((gpioPinOut & 8'h5a) === 8'h42 && gpioInVal === 8'h96, "gpio val");
        c = testChainOut;
        gpioPinIn <= 8'h97;
        step(6);
        expect_true(testChainOut === ~c, "chain flips");
    endtask

    task automatic t_mcu_clock_out();
        int t;
        for (int d = 0; d < 5; d++) begin
            @(posedge clk);
            mcuDivSel <= d[1:0];
            mcuStop <= (d == 4);
            step(20);
            t = 0;
            for (int i = 0; i < 32; i++) begin
                logic p;
                p = mcuClockOut;
                step(1);
                if (mcuClockOut !== p) t++;
            end
            expect_true(t == ((d == 4) ? 0 : (32 >> d)), "clock out rate");
        end
        mcuStop <= 1'b0;
    endtask

    task automatic t_dma();
        int p;
        p = 0;
        step(10);
        for (int i = 0; i < 60; i++) begin
            step(1);
            if (dmaClkEn === 1'b1) p++;
        end
        expect_true(p == 60 / DMA_INT_DIV, "internal dma tick");
        dmaClkSelExt <= 1'b1;
        step(10);
        p = 0;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            dmaAltClock <= (i % 10) < 5;
            #1;
            if (dmaClkEn === 1'b1) p++;
        end
        expect_true(p == 10, "external dma tick");
        dmaClkSelExt <= 1'b0;
    endtask

    task automatic t_por(input logic viaReset);
        @(posedge clk);
        if (viaReset) resetIn <= 1'b1;
        else powerGoodIn <= 1'b0;
        step(6);
        expect_true(coreRstN === 1'b0, "internal reset");
        if (!viaReset) begin
            expect_true({mcuClockOeN, portPowerOeN, flashAddrOeN, flashDataOeN, flashCtrlOeN,
                gpioPinOeN} === 13'h1fff && testChainOeN === 1'b0, "pins floated");
        end
        resetIn <= 1'b0;
        powerGoodIn <= 1'b1;
        wait_core();
    endtask

    task automatic t_debug();
        @(posedge clk);
        factoryTestN <= 1'b0;
        step(10);
        expect_true(debugMode === 1'b0 && testChainOeN === 1'b1, "chain released");
        tbChain <= 1'b0;
        step(10);
        expect_true(debugMode === 1'b1 && flashCtrlOeN === 1'b1, "debug entry");
        factoryTestN <= 1'b1;
        tbChain <= 1'b1;
        step(10);
        expect_true(debugMode === 1'b0, "debug exit");
    endtask

    initial begin
        #200000;
        nMismatch++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end

    initial begin
        step(6);
        rstn <= 1'b1;
        wait_core();
        t_defaults();
        t_flash();
        t_ports();
        t_gpio();
        t_mcu_clock_out();
        t_dma();
        t_por(1'b0);
        t_por(1'b1);
        t_debug();
        close_out();
    end
endmodule // ccrpc_chip_control_tb
